// ===== lopd_bench.sv
module lopd_bench
  import lopd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Design and loads
  // ****************************************************************
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout;
  logic hresp;
  logic [16:0] pins;
  logic [16:0] po;
  logic [16:0] poe;
  int failures = 0;
  int cmp_count = 0;
  logic [7:0] ro [7] = '{OFS_CONFIG, OFS_PHASE0_LO, OFS_PHASE_LAST, OFS_MASTER, OFS_INT_BASE,
    OFS_PHASE1_HI, OFS_INT_LAST};
  logic [7:0] rv [7] = '{8'h00, 8'hff, 8'h03, 8'h00, 8'hff, 8'hff, 8'hff};
  logic [11:0] tc [9] = '{12'hf00, 12'hfe0, 12'hf01, 12'hfe1, 12'hff0, 12'hff1, 12'h170,
    12'he31, 12'h050};

  always #5 hclk = ~hclk;

  lopd_top #(.STEP_CYCLES(2)) lopd_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
    .output_ports_i(pins), .output_ports_o(po), .output_ports_oe(poe));
  lopd_loads lopd_loads_i (.drive_o(po), .drive_oe(poe), .pin_level(pins));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Entered just after a rising edge; returns at the edge that ends the data phase.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Two clock cycles per step, so one period of 240 steps is 480 cycles.
  function automatic int want(logic [11:0] c);
    if (c[7:4] == 4'hf || c[11:8] == 4'h0)
      return c[0] ? 0 : 480;
    return c[11:8] * (c[0] ? 15 - c[7:4] : c[7:4] + 1) * 2;
  endfunction

  task automatic duty(input int exp);
    int n;
    n = 0;
    repeat (480)
    begin
      @(posedge hclk);
      n += (poe[0] === 1'b1);
    end
    check("sink cycles", exp, n);
  endtask

  // Outputs 8 to 16 share output 0's setting; output 1's inverted low span must cover 0's.
  task automatic aligned();
    int n;
    n = 0;
    repeat (480)
    begin
      @(posedge hclk);
      n += (poe[16:8] !== {9{poe[0]}}) || (poe[0] === 1'b1 && poe[1] !== 1'b1);
    end
    check("misaligned cycles", 0, n);
  endtask

  task automatic pins_after(input logic [16:0] exp);
    repeat (2) @(posedge hclk);
    check("sink pins", {15'h0, exp}, {15'h0, poe});
  endtask

  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (ro[i])
    begin
      bus(1'b0, {24'h0, ro[i]}, 32'h0);
      check("reset value", {24'h0, rv[i]}, rd);
    end
    pins_after(17'h0);
    bus(1'b0, {24'h0, OFS_STATUS}, 32'h0);
    check("stopped timebase", 32'h0, rd);
    bus(1'b1, 32'h100, 32'h5a);
    bus(1'b0, 32'h100, 32'h0);
    check("unmapped", 32'h0, rd);
    $display("test reset done");
    bus(1'b1, {24'h0, OFS_PHASE0_LO}, 32'h0);
    pins_after(17'h000ff);
    bus(1'b1, {24'h0, OFS_PHASE0_HI}, 32'h0);
    pins_after(17'h0ffff);
    bus(1'b1, {24'h0, OFS_PHASE_LAST}, 32'h2);
    pins_after(17'h1ffff);
    repeat (10) @(posedge hclk);
    bus(1'b0, {24'h0, OFS_PIN_STATE}, 32'h0);
    check("pin state", 32'h0, rd);
    bus(1'b1, {24'h0, OFS_CONFIG}, 32'h6);
    pins_after(17'h0);
    bus(1'b1, {24'h0, OFS_CONFIG}, 32'h0);
    $display("test groups done");
    foreach (tc[i])
    begin
      bus(1'b1, {24'h0, OFS_MASTER}, {24'h0, tc[i][11:8], 4'hf});
      bus(1'b1, {24'h0, OFS_INT_BASE}, {24'h0, 4'hf, tc[i][7:4]});
      bus(1'b1, {24'h0, OFS_PHASE0_LO}, {24'h0, 7'h7f, tc[i][0]});
      repeat (4) @(posedge hclk);
      duty(want(tc[i]));
    end
    $display("test duty done");
    bus(1'b1, {24'h0, OFS_CONFIG}, 32'h1);
    bus(1'b1, {24'h0, OFS_MASTER}, 32'hf3);
    bus(1'b1, {24'h0, OFS_INT_BASE}, 32'hfe);
    bus(1'b1, {24'h0, OFS_PHASE0_LO}, 32'hfe);
    repeat (4) @(posedge hclk);
    duty(120);
    aligned();
    $display("test global done");
    complete_run();
  end

  initial
  begin
    #200000;
    failures++;
    complete_run();
  end
endmodule

// ===== lopd_channel.sv
module lopd_channel
  import lopd_pkg::*;
(
  // Settings
  input wire logic [3:0] intensity,
  input wire logic phase_bit,
  input wire logic [3:0] master,
  // Timebase
  input wire logic running,
  input wire logic [3:0] step,
  input wire logic [3:0] slot,
  // Result: one means the pin sinks current
  output logic sink
);

  always_comb
  begin
    if (intensity == INT_STATIC)
      sink = ~phase_bit;
    else if (!running)
      sink = ~phase_bit;
    else if (slot >= master)
      sink = 1'b0;
    else if (!phase_bit)
      sink = (step <= intensity);
    else
      sink = (step < (STEPS_PER_SLOT_M1 - intensity));
  end

endmodule

// ===== lopd_loads.sv
module lopd_loads
  import lopd_pkg::*;
(
  // Design side
  input wire logic [16:0] drive_o,
  input wire logic [16:0] drive_oe,
  // Pin levels seen back
  output logic [16:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;

  // Every pin has a pull-up, so a released pin reads high.
  assign pin_level = ~drive_oe | drive_o;
endmodule

// ===== lopd_pkg.sv
package lopd_pkg;

  // ****************************************************************
  // Output and intensity geometry
  // ****************************************************************
  localparam int unsigned NUM_OUTPUTS = 17;
  localparam int unsigned INT_W = 4;
  localparam logic [3:0] INT_STATIC = 4'hf;
  localparam logic [3:0] STEPS_PER_SLOT_M1 = 4'hf;
  localparam logic [3:0] SLOTS_PER_PERIOD_M1 = 4'he;
  localparam logic [3:0] MASTER_OFF = 4'h0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  localparam int unsigned PWM_OSC_HZ = 32_000;
  localparam int unsigned PWM_STEP_CYCLES = CLK_FREQ_HZ / PWM_OSC_HZ;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_PHASE0_LO = 8'h04;
  localparam logic [7:0] OFS_PHASE0_HI = 8'h08;
  localparam logic [7:0] OFS_PHASE1_LO = 8'h0c;
  localparam logic [7:0] OFS_PHASE1_HI = 8'h10;
  localparam logic [7:0] OFS_PHASE_LAST = 8'h14;
  localparam logic [7:0] OFS_MASTER = 8'h18;
  localparam logic [7:0] OFS_INT_BASE = 8'h1c;
  localparam logic [7:0] OFS_INT_LAST = 8'h38;
  localparam logic [7:0] OFS_STATUS = 8'h3c;
  localparam logic [7:0] OFS_PIN_STATE = 8'h40;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int unsigned CFG_GLOBAL_BIT = 0;
  localparam int unsigned CFG_BLINK_EN_BIT = 1;
  localparam int unsigned CFG_BLINK_SEL_BIT = 2;
  localparam int unsigned MASTER_LSB = 4;
  localparam int unsigned STAT_SLOT_LSB = 4;
  localparam int unsigned STAT_RUN_BIT = 8;
  localparam logic [2:0] CONFIG_RESET = 3'h0;
  localparam logic [7:0] PHASE_RESET = 8'hff;
  localparam logic [1:0] PHASE_LAST_RESET = 2'h3;
  localparam logic [7:0] MASTER_RESET = 8'h00;
  localparam logic [7:0] INT_RESET = 8'hff;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// ===== lopd_properties.sv
module lopd_properties
  import lopd_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pins
  input wire logic [16:0] output_ports_o,
  input wire logic [16:0] output_ports_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Shadow of bus writes
  // ****************************************************************
  logic wp;
  logic wm;
  logic wrote;
  logic [2:0] quiet;
  logic [3:0] mst;
  wire logic take = hsel && hready && htrans == HTRANS_NONSEQ;

  // A write reaches the pins two edges after its data phase, so quiet must saturate first.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wp <= 1'b0;
      wm <= 1'b0;
      wrote <= 1'b0;
      quiet <= 3'h0;
      mst <= MASTER_RESET[7:4];
    end
    else
    begin
      wp <= take && hwrite;
      wm <= take && hwrite && haddr == {24'h0, OFS_MASTER};
      wrote <= wrote | wp;
      quiet <= wp ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
      if (wm && hready)
        mst <= hwdata[7:4];
    end
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence rd_at(logic [7:0] ofs);
    take && !hwrite && haddr == {24'h0, ofs};
  endsequence

  okay_resp_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  ready_high_a: assert property ($past(hresetn) |-> hreadyout)
    else $error("ready low after reset");
  drive_zero_a: assert property (output_ports_o == 17'h0)
    else $error("output data not zero");
  unmapped_read_a: assert property (take && !hwrite && haddr[31:8] != 24'h0 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  master_pad_a: assert property (rd_at(OFS_MASTER) |=> hrdata[31:8] == 24'h0)
    else $error("master read upper bits set");
  status_range_a: assert property (rd_at(OFS_STATUS) |=>
    hrdata[7:4] <= SLOTS_PER_PERIOD_M1 && hrdata[31:9] == 23'h0)
    else $error("slot out of range");
  reset_float_a: assert property (!wrote |-> output_ports_oe == 17'h0)
    else $error("pin sinks before any write");
  master_off_a: assert property (quiet == 3'h7 && mst == MASTER_OFF |->
    $stable(output_ports_oe))
    else $error("pins move with master off");
endmodule

bind lopd_top lopd_properties lopd_properties_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .output_ports_o, .output_ports_oe);

// ===== lopd_timebase.sv
module lopd_timebase
  import lopd_pkg::*;
#(
  parameter int unsigned DIV_CYCLES = PWM_STEP_CYCLES
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic [3:0] master,
  // Timebase
  output logic running,
  output logic [3:0] step,
  output logic [3:0] slot
);

  localparam int unsigned DIV_W = $clog2(DIV_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_CYCLES - 1);

  logic [DIV_W-1:0] div_reg;
  logic step_en;

  // The oscillator stands still while master intensity is zero.
  assign running = (master != MASTER_OFF);
  assign step_en = running && (div_reg == DIV_LAST);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div_reg <= '0;
    else if (!running || step_en)
      div_reg <= '0;
    else
      div_reg <= div_reg + DIV_W'(1);
  end

  // 240-step period: 15 slots of 16 steps each.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      step <= 4'h0;
      slot <= 4'h0;
    end
    else if (!running)
    begin
      step <= 4'h0;
      slot <= 4'h0;
    end
    else if (step_en)
    begin
      step <= step + 4'h1;
      if (step == STEPS_PER_SLOT_M1)
        slot <= (slot == SLOTS_PER_PERIOD_M1) ? 4'h0 : slot + 4'h1;
    end
  end

endmodule

// ===== lopd_top.sv
// Implementation choices: the address map and the AHB-Lite slave port.
module lopd_top
  import lopd_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = PWM_STEP_CYCLES
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Open-drain output ports
  input wire logic [16:0] output_ports_i,
  output logic [16:0] output_ports_o,
  output logic [16:0] output_ports_oe
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [3:0] int_field(input logic [7:0] regs [8], input int unsigned idx);
    logic [7:0] pair;
    pair = regs[idx / 2];
    return (idx % 2 == 0) ? pair[3:0] : pair[7:4];
  endfunction

  function automatic logic is_int_addr(input logic [7:0] a);
    return (a >= OFS_INT_BASE) && (a <= OFS_INT_LAST);
  endfunction

  // Only the lowest 256 bytes decode; anything above reads zero and ignores writes.
  function automatic logic in_map(input logic [31:0] a);
    return (a[31:8] == 24'h000000);
  endfunction

  // Intensity words are whole words; an unaligned offset in their range is unmapped.
  function automatic logic int_hit(input logic [7:0] a);
    return is_int_addr(a) && (a[1:0] == 2'h0);
  endfunction

  // The base is not a multiple of 32, so the index wraps through the subtraction.
  function automatic logic [2:0] int_index(input logic [7:0] a);
    return 3'(a[4:2] - OFS_INT_BASE[4:2]);
  endfunction

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [2:0] config_reg;
  logic [7:0] phase0_lo_reg;
  logic [7:0] phase0_hi_reg;
  logic [7:0] phase1_lo_reg;
  logic [7:0] phase1_hi_reg;
  logic [1:0] phase_last_reg;
  logic [7:0] master_reg;
  logic [7:0] int_reg [8];
  logic [16:0] pin_state_reg;

  // Timebase outputs, read back through the status word.
  logic running;
  logic [3:0] step;
  logic [3:0] slot;

  // Data-phase bookkeeping.
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic addr_valid;
  logic [7:0] addr_ofs;
  logic [31:0] rdata_next;

  assign addr_valid = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign addr_ofs = haddr[7:0];

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  // Zero wait states: every transfer completes in its first data cycle.
  // The transfer size is not decoded, since every register is a whole word.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= addr_valid && hwrite && in_map(haddr);
      wr_addr_reg <= addr_ofs;
    end
  end

  // Read data is sampled at the address phase so hrdata is a plain flop.
  // The price: a read right behind a write to the same register returns the old value.
  always_comb
  begin
    rdata_next = 32'h00000000;
    if (in_map(haddr))
    begin
      case (addr_ofs)
        OFS_CONFIG: rdata_next[2:0] = config_reg;
        OFS_PHASE0_LO: rdata_next[7:0] = phase0_lo_reg;
        OFS_PHASE0_HI: rdata_next[7:0] = phase0_hi_reg;
        OFS_PHASE1_LO: rdata_next[7:0] = phase1_lo_reg;
        OFS_PHASE1_HI: rdata_next[7:0] = phase1_hi_reg;
        OFS_PHASE_LAST: rdata_next[1:0] = phase_last_reg;
        OFS_MASTER: rdata_next[7:0] = master_reg;
        OFS_STATUS:
        begin
          rdata_next[3:0] = step;
          rdata_next[STAT_SLOT_LSB +: 4] = slot;
          rdata_next[STAT_RUN_BIT] = running;
        end
        OFS_PIN_STATE: rdata_next[16:0] = pin_state_reg;
        default:
        begin
          if (int_hit(addr_ofs))
            rdata_next[7:0] = int_reg[int_index(addr_ofs)];
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (addr_valid && !hwrite)
      hrdata <= rdata_next;
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      config_reg <= CONFIG_RESET;
    else if (wr_pend_reg && (wr_addr_reg == OFS_CONFIG))
      config_reg <= hwdata[2:0];
  end

  // Master and output 16 intensity share one word, so both change together.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      master_reg <= MASTER_RESET;
    else if (wr_pend_reg && (wr_addr_reg == OFS_MASTER))
      master_reg <= hwdata[7:0];
  end

  // Each group of eight outputs changes with one write; output 16 alone.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase0_lo_reg <= PHASE_RESET;
      phase0_hi_reg <= PHASE_RESET;
      phase1_lo_reg <= PHASE_RESET;
      phase1_hi_reg <= PHASE_RESET;
      phase_last_reg <= PHASE_LAST_RESET;
    end
    else if (wr_pend_reg)
    begin
      case (wr_addr_reg)
        OFS_PHASE0_LO: phase0_lo_reg <= hwdata[7:0];
        OFS_PHASE0_HI: phase0_hi_reg <= hwdata[7:0];
        OFS_PHASE1_LO: phase1_lo_reg <= hwdata[7:0];
        OFS_PHASE1_HI: phase1_hi_reg <= hwdata[7:0];
        OFS_PHASE_LAST: phase_last_reg <= hwdata[1:0];
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int k = 0; k < 8; k++)
        int_reg[k] <= INT_RESET;
    end
    else if (wr_pend_reg && int_hit(wr_addr_reg))
      int_reg[int_index(wr_addr_reg)] <= hwdata[7:0];
  end

  // Pin levels are taken as synchronous, so one register stage is enough.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pin_state_reg <= 17'h00000;
    else
      pin_state_reg <= output_ports_i;
  end

  // ****************************************************************
  // PWM timebase
  // ****************************************************************
  lopd_timebase #(
    .DIV_CYCLES(STEP_CYCLES)
  ) u_timebase (
    .hclk(hclk),
    .hresetn(hresetn),
    .master(master_reg[MASTER_LSB +: 4]),
    .running(running),
    .step(step),
    .slot(slot)
  );

  // ****************************************************************
  // Per-output duty
  // ****************************************************************
  logic [15:0] phase0_bits;
  logic [15:0] phase1_bits;
  logic [16:0] active_phase;
  logic [16:0] sink;
  logic blink_sel;

  assign phase0_bits = {phase0_hi_reg, phase0_lo_reg};
  assign phase1_bits = {phase1_hi_reg, phase1_lo_reg};
  // Blink timing is generated elsewhere; software picks the live phase.
  assign blink_sel = config_reg[CFG_BLINK_EN_BIT] && config_reg[CFG_BLINK_SEL_BIT];

  // Every channel reads the one step and slot count, so all outputs share one
  // alignment and a setting change never shifts one output against another.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUTPUTS; gi++)
    begin : g_out
      logic [3:0] eff_int;
      if (gi < 16)
      begin : g_grp
        assign active_phase[gi] = blink_sel ? phase1_bits[gi] : phase0_bits[gi];
        assign eff_int = config_reg[CFG_GLOBAL_BIT] ? master_reg[3:0]
                         : int_field(int_reg, gi);
      end
      else
      begin : g_last
        assign active_phase[gi] = blink_sel ? phase_last_reg[1] : phase_last_reg[0];
        assign eff_int = master_reg[3:0];
      end
      lopd_channel u_chan (
        .intensity(eff_int),
        .phase_bit(active_phase[gi]),
        .master(master_reg[MASTER_LSB +: 4]),
        .running(running),
        .step(step),
        .slot(slot),
        .sink(sink[gi])
      );
    end
  endgenerate

  // Open drain: the data line always carries low, the enable sinks.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      output_ports_o <= 17'h00000;
      output_ports_oe <= 17'h00000;
    end
    else
    begin
      output_ports_o <= 17'h00000;
      output_ports_oe <= sink;
    end
  end

endmodule
